// File: logic/btsc_pkg.sv
// constants, types and carriers for the band timing and speed-control block
package btsc_pkg;

    // ********************************
    // clock
    // ********************************
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;

    // ********************************
    // widths
    // ********************************
    localparam int SPD_W = 11;
    localparam int GAP_W = 16;
    localparam int HAM_W = 12;
    localparam int POR_W = 24;
    localparam int SRST_W = 5;

    // ********************************
    // speed counter terminal counts, in timebase ticks
    // ********************************
    localparam logic [SPD_W-1:0] TC_SLOW = 11'h4c0;
    localparam logic [SPD_W-1:0] TC_MEDIUM = 11'h440;
    localparam logic [SPD_W-1:0] TC_FAST = 11'h340;

    // ********************************
    // timing
    // ********************************
    localparam int SPEED_RESET_NS = 800;
    localparam int SPEED_RESET_CYCLES = (SPEED_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MARK_SLOW_US = 611;
    localparam int MARK_MEDIUM_US = 889;
    localparam int MARK_FAST_US = 563;
    localparam logic [GAP_W-1:0] GAP_SLOW = GAP_W'(MARK_SLOW_US * CLK_MHZ / 2);
    localparam logic [GAP_W-1:0] GAP_MEDIUM = GAP_W'(MARK_MEDIUM_US * CLK_MHZ / 2);
    localparam logic [GAP_W-1:0] GAP_FAST = GAP_W'(MARK_FAST_US * CLK_MHZ / 2);
    localparam logic [GAP_W-1:0] GAP_MAX = 16'hffff;
    localparam int HAMMER_RESET_US = 100;
    localparam logic [HAM_W-1:0] HAMMER_RESET_CYCLES = HAM_W'(HAMMER_RESET_US * CLK_MHZ);
    localparam int POR_MS = 500;
    localparam int POR_CYCLES_DEF = POR_MS * 1000 * CLK_MHZ;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {MODEL_SLOW, MODEL_MEDIUM, MODEL_FAST} btsc_model_t;

    typedef enum logic [1:0] {IDX_WAIT, IDX_MASKED, IDX_FOUND} btsc_idx_t;

    typedef struct packed {
        logic index_clock;
        logic ident_clock;
        logic index_out_n;
        logic index_second_stage;
        logic hammer_trigger;
        logic hammer_reset;
    } btsc_proc_t;

    localparam btsc_proc_t PROC_RESET = 6'h08;

endpackage : btsc_pkg

// File: logic/btsc_pulse_stretch.sv
// fixed-length pulse generator started by a one-cycle trigger
`timescale 1ns/1ns
module btsc_pulse_stretch #(
    parameter int LEN = 20,
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trig,
    output logic pulse
);

    localparam logic [W-1:0] LOAD = W'(LEN);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (trig) begin
            next_cnt = LOAD;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign pulse = (cnt != '0);

endmodule : btsc_pulse_stretch

// File: logic/btsc_band_timing.sv
// band timing, speed control, index separation and power reset
//
// Notes on behaviour
// - band mark sampled into synced pulse
// - synced pulse trailing edge sets double clock
// - double clock rise clears counter 800 ns
// - counter terminal count clears double clock
// - slow model sets twice per character
// - terminal count first drives request low
// - early mark drives request high
// - nominal mark spacing per model
// - early marks are index or identifier
// - first extra masked, second sets index
// - initializer aligns slow divide-by-two
// - index given true and complemented
// - index, identifier, hammer references to processor
// - hammer references only in print mode
// - power reset held half a second
// - early warning low asserts reset immediately
// - print inhibit disables hammer drivers
`timescale 1ns/1ns
module btsc_band_timing #(
    parameter int POR_CYCLES = btsc_pkg::POR_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic band_mark_in,
    input wire logic system_timebase,
    input btsc_pkg::btsc_model_t model_sel,
    input wire logic print_mode,
    input wire logic print_inhibit,
    input wire logic supply_early_warning,
    output logic synced_mark_pulse,
    output logic char_clock_double,
    output logic char_clock,
    output logic speed_drive_request_n,
    output logic power_reset_n,
    output logic hammer_enable,
    output btsc_pkg::btsc_proc_t proc_out
);
    import btsc_pkg::*;

    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

    // ************************************************
    // model decode
    // ************************************************
    logic [SPD_W-1:0] tc;
    logic [GAP_W-1:0] extra_gap;

    always_comb begin
        case (model_sel)
            MODEL_SLOW: begin
                tc = TC_SLOW;
                extra_gap = GAP_SLOW;
            end
            MODEL_MEDIUM: begin
                tc = TC_MEDIUM;
                extra_gap = GAP_MEDIUM;
            end
            MODEL_FAST: begin
                tc = TC_FAST;
                extra_gap = GAP_FAST;
            end
            default: begin
                tc = TC_SLOW;
                extra_gap = GAP_SLOW;
            end
        endcase
    end

    // ************************************************
    // mark sampling and classification
    // ************************************************
    logic mark_prev;
    logic tb_prev;
    logic next_synced;
    logic next_mark_prev;
    logic next_tb_prev;
    logic [GAP_W-1:0] gap;
    logic [GAP_W-1:0] next_gap;
    logic mark_fall;
    logic tb_tick;
    logic extra_fall;
    logic valid_fall;

    always_comb begin
        next_synced = band_mark_in;
        next_mark_prev = synced_mark_pulse;
        next_tb_prev = system_timebase;
        mark_fall = mark_prev && !synced_mark_pulse;
        tb_tick = system_timebase && !tb_prev;
        // marks closer than half the nominal spacing are not characters
        extra_fall = mark_fall && (gap < extra_gap);
        valid_fall = mark_fall && !extra_fall;
        next_gap = gap;
        if (mark_fall) begin
            next_gap = '0;
        end else if (gap != GAP_MAX) begin
            next_gap = gap + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            synced_mark_pulse <= 1'b0;
            mark_prev <= 1'b0;
            tb_prev <= 1'b0;
            gap <= GAP_MAX;
        end else begin
            synced_mark_pulse <= next_synced;
            mark_prev <= next_mark_prev;
            tb_prev <= next_tb_prev;
            gap <= next_gap;
        end
    end

    // ************************************************
    // index and identifier separation
    // ************************************************
    btsc_idx_t idx;
    btsc_idx_t next_idx;
    logic raw_index_n;
    logic ident_pulse;

    always_comb begin
        next_idx = idx;
        raw_index_n = 1'b1;
        ident_pulse = 1'b0;
        if (valid_fall) begin
            next_idx = IDX_WAIT;
        end else if (extra_fall) begin
            case (idx)
                IDX_WAIT: begin
                    next_idx = IDX_MASKED;
                end
                IDX_MASKED: begin
                    next_idx = IDX_FOUND;
                    raw_index_n = 1'b0;
                end
                IDX_FOUND: begin
                    ident_pulse = 1'b1;
                end
                default: begin
                    next_idx = IDX_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idx <= IDX_WAIT;
        end else begin
            idx <= next_idx;
        end
    end

    // ************************************************
    // character clock and speed servo
    // ************************************************
    logic [SPD_W-1:0] spd_cnt;
    logic [SPD_W-1:0] next_spd_cnt;
    logic ccd_prev;
    logic next_ccd;
    logic next_ccd_prev;
    logic next_drive;
    logic div;
    logic next_div;
    logic init_ff;
    logic next_init;
    logic next_char_clock;
    logic ccd_rise;
    logic spd_clear;
    logic tc_hit;
    logic char_event;

    btsc_pulse_stretch #(
        .LEN(SPEED_RESET_CYCLES),
        .W(SRST_W)
    ) u_speed_reset (
        .clk(clk),
        .resetn(resetn),
        .trig(ccd_rise),
        .pulse(spd_clear)
    );

    always_comb begin
        ccd_rise = char_clock_double && !ccd_prev;
        tc_hit = tb_tick && !spd_clear && (spd_cnt == tc - 1'b1);
        next_ccd_prev = char_clock_double;
        next_spd_cnt = spd_cnt;
        if (spd_clear) begin
            next_spd_cnt = '0;
        end else if (tb_tick && (spd_cnt != tc)) begin
            next_spd_cnt = spd_cnt + 1'b1;
        end
        // a new mark wins over the terminal count
        next_ccd = char_clock_double;
        if (valid_fall) begin
            next_ccd = 1'b1;
        end else if (tc_hit) begin
            next_ccd = 1'b0;
        end
        next_drive = speed_drive_request_n;
        if (!power_reset_n) begin
            next_drive = 1'b1;
        end else if (valid_fall && (spd_cnt != tc)) begin
            next_drive = 1'b1;
        end else if (tc_hit) begin
            next_drive = 1'b0;
        end
        next_div = div;
        next_init = init_ff;
        char_event = 1'b0;
        if (ccd_rise) begin
            if (model_sel != MODEL_SLOW) begin
                char_event = 1'b1;
            end else if (init_ff) begin
                next_div = 1'b1;
                next_init = 1'b0;
                char_event = 1'b1;
            end else begin
                next_div = !div;
                char_event = !div;
            end
        end
        if (!raw_index_n) begin
            next_init = 1'b1;
        end
        next_char_clock = (model_sel == MODEL_SLOW) ? next_div : next_ccd;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spd_cnt <= '0;
            char_clock_double <= 1'b0;
            ccd_prev <= 1'b0;
            speed_drive_request_n <= 1'b1;
            div <= 1'b0;
            init_ff <= 1'b1;
            char_clock <= 1'b0;
        end else begin
            spd_cnt <= next_spd_cnt;
            char_clock_double <= next_ccd;
            ccd_prev <= next_ccd_prev;
            speed_drive_request_n <= next_drive;
            div <= next_div;
            init_ff <= next_init;
            char_clock <= next_char_clock;
        end
    end

    // ************************************************
    // processor references and hammer gating
    // ************************************************
    logic [HAM_W-1:0] ham_cnt;
    logic [HAM_W-1:0] next_ham_cnt;
    btsc_proc_t next_proc;
    logic next_hammer_enable;
    logic hammer_ok;

    always_comb begin
        hammer_ok = print_mode && !print_inhibit && power_reset_n;
        next_ham_cnt = ham_cnt;
        if (char_event && hammer_ok) begin
            next_ham_cnt = HAMMER_RESET_CYCLES;
        end else if (ham_cnt != '0) begin
            next_ham_cnt = ham_cnt - 1'b1;
        end
        next_proc.index_clock = !raw_index_n;
        next_proc.ident_clock = ident_pulse;
        next_proc.index_out_n = (next_idx != IDX_FOUND);
        next_proc.index_second_stage = !proc_out.index_out_n;
        next_proc.hammer_trigger = char_event && hammer_ok;
        next_proc.hammer_reset = (ham_cnt == 12'h001) && hammer_ok;
        next_hammer_enable = !print_inhibit && power_reset_n;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ham_cnt <= '0;
            proc_out <= PROC_RESET;
            hammer_enable <= 1'b0;
        end else begin
            ham_cnt <= next_ham_cnt;
            proc_out <= next_proc;
            hammer_enable <= next_hammer_enable;
        end
    end

    // ************************************************
    // power reset sequence
    // ************************************************
    logic [POR_W-1:0] por_cnt;
    logic [POR_W-1:0] next_por_cnt;
    logic next_power_reset_n;

    always_comb begin
        next_por_cnt = por_cnt;
        next_power_reset_n = 1'b0;
        if (!supply_early_warning) begin
            next_por_cnt = '0;
        end else if (por_cnt != POR_LAST) begin
            next_por_cnt = por_cnt + 1'b1;
        end else begin
            next_power_reset_n = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            por_cnt <= '0;
            power_reset_n <= 1'b0;
        end else begin
            por_cnt <= next_por_cnt;
            power_reset_n <= next_power_reset_n;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_mark_sample: assert property (
        $fell(synced_mark_pulse) |-> $past(band_mark_in, 2) && !$past(band_mark_in))
        else $error("synced mark does not follow band mark");
    chk_double_set: assert property (
        valid_fall |=> char_clock_double)
        else $error("double clock not set by mark");
    chk_clear_pulse: assert property (
        $rose(char_clock_double) |=> spd_clear [*8])
        else $error("speed counter clear too short");
    chk_tc_clear: assert property (
        tc_hit && !valid_fall |=> !char_clock_double)
        else $error("terminal count did not clear double clock");
    chk_slow_div: assert property (
        model_sel == MODEL_SLOW && ccd_rise && !init_ff && div |=> !char_clock && !proc_out.hammer_trigger)
        else $error("slow divider gave a character on the second half");
    chk_init_align: assert property (
        model_sel == MODEL_SLOW && ccd_rise && init_ff && raw_index_n |=> char_clock && !init_ff)
        else $error("initializer did not align slow divider");
    chk_div_phase: assert property (
        model_sel == MODEL_SLOW && ccd_rise && !init_ff |=> char_clock != $past(div))
        else $error("slow divider did not toggle");
    chk_slow_request: assert property (
        tc_hit && !valid_fall && power_reset_n |=> !speed_drive_request_n)
        else $error("no speed-up request at terminal count");
    chk_fast_release: assert property (
        valid_fall && spd_cnt != tc |=> speed_drive_request_n)
        else $error("no slow-down on early mark");
    chk_drive_hold: assert property (
        power_reset_n && !valid_fall && !tc_hit |=> $stable(speed_drive_request_n))
        else $error("drive request changed without cause");
    chk_reset_slow: assert property (
        !power_reset_n |=> speed_drive_request_n)
        else $error("drive request low during power reset");
    chk_index_mask: assert property (
        extra_fall && idx == IDX_WAIT |=> !proc_out.index_clock && idx == IDX_MASKED)
        else $error("first extra mark not masked");
    chk_index_found: assert property (
        extra_fall && idx == IDX_MASKED |=> proc_out.index_clock && !proc_out.index_out_n)
        else $error("index not raised on second extra mark");
    chk_hammer_gate: assert property (
        proc_out.hammer_trigger |-> $past(print_mode) && !$past(print_inhibit))
        else $error("hammer trigger outside print mode");
    chk_inhibit: assert property (
        print_inhibit |=> !hammer_enable)
        else $error("hammer drivers enabled under inhibit");
    chk_warn_reset: assert property (
        !supply_early_warning |=> !power_reset_n)
        else $error("power reset not asserted on early warning");
    chk_por_hold: assert property (
        $rose(power_reset_n) |-> $past(por_cnt) == POR_LAST && $past(supply_early_warning))
        else $error("power reset released early");

endmodule : btsc_band_timing

// File: bench/btsc_band_model.sv
// band transducer and processor timebase stand-in
`timescale 1ns/1ns
module btsc_band_model (
    input wire logic clk,
    output logic band_mark_in,
    output logic system_timebase
);
    int tb_half = 1;
    int tb_cnt = 0;

    initial begin
        band_mark_in = 1'b0;
        system_timebase = 1'b0;
    end

    // free-running timebase, half period in clocks set by the bench
    always @(negedge clk) begin
        if (tb_cnt + 1 >= tb_half) begin
            tb_cnt <= 0;
            system_timebase <= ~system_timebase;
        end else begin
            tb_cnt <= tb_cnt + 1;
        end
    end

    // one squared mark, idle level low between marks
    task automatic mark(input int width);
        @(negedge clk);
        band_mark_in = 1'b1;
        repeat (width) @(negedge clk);
        band_mark_in = 1'b0;
    endtask : mark
endmodule : btsc_band_model

// File: bench/btsc_band_timing_tb.sv
// self-checking bench for the band timing and speed-control block
`timescale 1ns/1ns
`define BT_CHECK(name, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("Error %s expected %h seen %h", name, exp, got); \
        end \
    end
module btsc_band_timing_tb;
    import btsc_pkg::*;
    localparam int POR_SIM = 20;
    localparam int MARK_W = 10;
    typedef struct {btsc_model_t model; int tbh; int gap; logic ccd; logic drv; logic cc; int trig;} btsc_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic band_mark_in;
    logic system_timebase;
    btsc_model_t model_sel = MODEL_SLOW;
    logic print_mode = 1'b1;
    logic print_inhibit = 1'b0;
    logic supply_early_warning = 1'b1;
    logic synced_mark_pulse;
    logic char_clock_double;
    logic char_clock;
    logic speed_drive_request_n;
    logic power_reset_n;
    logic hammer_enable;
    btsc_proc_t proc_out;
    int errors = 0;
    int n_checks = 0;
    int n_trig = 0;
    int n_hres = 0;
    int n_idx = 0;
    int n_ident = 0;
    int n_sync = 0;
    int t0;
    int s0;
    int h0;
    int i0;
    int d0;
    btsc_row_t rows [6] = '{
        '{MODEL_SLOW, 1, 7700, 1'b0, 1'b0, 1'b0, 0}, '{MODEL_SLOW, 8, 7700, 1'b1, 1'b1, 1'b0, 0},
        '{MODEL_MEDIUM, 1, 11200, 1'b0, 1'b0, 1'b1, 1}, '{MODEL_MEDIUM, 8, 11200, 1'b1, 1'b1, 1'b1, 0},
        '{MODEL_FAST, 1, 7100, 1'b0, 1'b0, 1'b1, 1}, '{MODEL_FAST, 8, 7100, 1'b1, 1'b1, 1'b1, 0}};

    always #20 clk = ~clk;

    btsc_band_model band (
        .clk(clk),
        .band_mark_in(band_mark_in),
        .system_timebase(system_timebase)
    );

    btsc_band_timing #(.POR_CYCLES(POR_SIM)) dut (
        .clk(clk),
        .resetn(resetn),
        .band_mark_in(band_mark_in),
        .system_timebase(system_timebase),
        .model_sel(model_sel),
        .print_mode(print_mode),
        .print_inhibit(print_inhibit),
        .supply_early_warning(supply_early_warning),
        .synced_mark_pulse(synced_mark_pulse),
        .char_clock_double(char_clock_double),
        .char_clock(char_clock),
        .speed_drive_request_n(speed_drive_request_n),
        .power_reset_n(power_reset_n),
        .hammer_enable(hammer_enable),
        .proc_out(proc_out)
    );

    // ********************************
    // pulse counters
    // ********************************
    // counted on the falling edge, away from the launching edge, so registered outputs are settled
    always @(negedge clk) begin
        if (proc_out.hammer_trigger === 1'b1) n_trig++;
        if (proc_out.hammer_reset === 1'b1) n_hres++;
        if (proc_out.index_clock === 1'b1) n_idx++;
        if (proc_out.ident_clock === 1'b1) n_ident++;
        if (synced_mark_pulse === 1'b1) n_sync++;
    end

    // ********************************
    // tasks
    // ********************************
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic do_reset(input btsc_model_t m);
        @(negedge clk);
        resetn = 1'b0;
        model_sel = m;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (POR_SIM + 10) @(negedge clk);
    endtask : do_reset

    task automatic mark_settle(input int gap);
        repeat (gap) @(negedge clk);
        band.mark(MARK_W);
        repeat (6) @(negedge clk);
    endtask : mark_settle

    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        complete_run();
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        for (int i = 0; i < 6; i++) begin
            if (i % 2 == 0) begin
                do_reset(rows[i].model);
                band.mark(MARK_W);
            end
            band.tb_half = rows[i].tbh;
            repeat (rows[i].gap) @(negedge clk);
            `BT_CHECK("char_clock_double before mark", rows[i].ccd, char_clock_double)
            t0 = n_trig;
            s0 = n_sync;
            mark_settle(0);
            `BT_CHECK("char_clock_double", 1'b1, char_clock_double)
            `BT_CHECK("speed_drive_request_n", rows[i].drv, speed_drive_request_n)
            `BT_CHECK("char_clock", rows[i].cc, char_clock)
            `BT_CHECK("hammer_trigger count", rows[i].trig, n_trig - t0)
            `BT_CHECK("synced mark cycles", MARK_W, n_sync - s0)
        end
        // index and identifier separation, slow divider alignment
        do_reset(MODEL_SLOW);
        band.tb_half = 1;
        band.mark(MARK_W);
        i0 = n_idx;
        d0 = n_ident;
        for (int k = 1; k <= 4; k++) begin
            mark_settle(200);
            `BT_CHECK("index_clock count", (k >= 2) ? 1 : 0, n_idx - i0)
            `BT_CHECK("ident_clock count", (k >= 3) ? k - 2 : 0, n_ident - d0)
        end
        `BT_CHECK("index_out_n", 1'b0, proc_out.index_out_n)
        `BT_CHECK("index_second_stage", 1'b1, proc_out.index_second_stage)
        mark_settle(7700);
        `BT_CHECK("char_clock after index", 1'b1, char_clock)
        `BT_CHECK("index_out_n after mark", 1'b1, proc_out.index_out_n)
        // hammer references, inhibit and print mode
        do_reset(MODEL_FAST);
        t0 = n_trig;
        h0 = n_hres;
        mark_settle(0);
        repeat (2520) @(negedge clk);
        `BT_CHECK("hammer_trigger count", 1, n_trig - t0)
        `BT_CHECK("hammer_reset count", 1, n_hres - h0)
        print_inhibit = 1'b1;
        repeat (2) @(negedge clk);
        `BT_CHECK("hammer_enable inhibited", 1'b0, hammer_enable)
        mark_settle(7100);
        `BT_CHECK("hammer_trigger inhibited", 1, n_trig - t0)
        print_inhibit = 1'b0;
        repeat (2) @(negedge clk);
        `BT_CHECK("hammer_enable", 1'b1, hammer_enable)
        print_mode = 1'b0;
        mark_settle(7100);
        `BT_CHECK("hammer_trigger outside print", 1, n_trig - t0)
        print_mode = 1'b1;
        // supply loss while speeding up
        repeat (2000) @(negedge clk);
        `BT_CHECK("speed_drive_request_n slow band", 1'b0, speed_drive_request_n)
        supply_early_warning = 1'b0;
        @(negedge clk);
        `BT_CHECK("power_reset_n on supply loss", 1'b0, power_reset_n)
        @(negedge clk);
        `BT_CHECK("speed_drive_request_n in power reset", 1'b1, speed_drive_request_n)
        `BT_CHECK("hammer_enable in power reset", 1'b0, hammer_enable)
        supply_early_warning = 1'b1;
        repeat (15) @(negedge clk);
        `BT_CHECK("power_reset_n held", 1'b0, power_reset_n)
        repeat (10) @(negedge clk);
        `BT_CHECK("power_reset_n released", 1'b1, power_reset_n)
        // reset in mid-run
        resetn = 1'b0;
        @(negedge clk);
        `BT_CHECK("proc_out in reset", PROC_RESET, proc_out)
        `BT_CHECK("speed_drive_request_n in reset", 1'b1, speed_drive_request_n)
        `BT_CHECK("char_clock_double in reset", 1'b0, char_clock_double)
        `BT_CHECK("power_reset_n in reset", 1'b0, power_reset_n)
        resetn = 1'b1;
        repeat (15) @(negedge clk);
        `BT_CHECK("power_reset_n after reset", 1'b0, power_reset_n)
        repeat (10) @(negedge clk);
        `BT_CHECK("power_reset_n after delay", 1'b1, power_reset_n)
        complete_run();
    end
endmodule : btsc_band_timing_tb
